// ### inc/ocpwm_pkg.sv
// Constants, field layout and carrier types of the output compare / PWM unit
//
// How it works
// - PWM period is timer_period plus one counts of the time base.
// - Duty values written any time take effect only at the period match.
// - Primary, secondary and period all zero keep the pin low.
// - Secondary above period keeps the pin high the whole time.
// - Time base select: 111 sys, 100 timer1, 011 t5, 010 t4, 001 t3.
// - Fault enable bits 9, 8, 7 arm comparator, pin B and pin A.
// - Hardware sets fault status bits 6, 5, 4 when a fault occurs.
// - Fault enable and status act only in the two PWM modes.
// - With trigger status mode set, a secondary match clears trigger status.
// - Mode 111 center PWM, 110 edge PWM, 000 channel off.
// - Mode 101 starts low, toggles on alternate primary and secondary matches.
// - Mode 100 starts low, one pulse from primary to secondary match.
// - 011 toggles per primary match; 010 starts high, goes low; 001 the reverse.
// - Fault direction bit set forces the pin to output during a fault.
// - Invert bit inverts the polarity driven to the pin.
// - Fine duty delays the falling edge; buffered only in PWM modes.
// - Cascade enable joins this channel and its partner into 32 bits.
// - Trigger select set triggers, clear synchronises; status shows running.
// - Sync source 11111 is this channel, 00000 free running.
package ocpwm_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OCPWM_ADDR_CTRL1  = 8'h00;
   localparam logic [7:0] OCPWM_ADDR_CTRL2  = 8'h04;
   localparam logic [7:0] OCPWM_ADDR_PRI    = 8'h08;
   localparam logic [7:0] OCPWM_ADDR_SEC    = 8'h0C;
   localparam logic [7:0] OCPWM_ADDR_PERIOD = 8'h10;
   localparam logic [7:0] OCPWM_ADDR_STATUS = 8'h14;

   localparam logic [15:0] OCPWM_CTRL1_RESET = 16'h0000;
   localparam logic [15:0] OCPWM_CTRL2_RESET = 16'h000C;
   localparam logic [15:0] OCPWM_CTRL1_WMASK = 16'h3FFF;
   localparam logic [15:0] OCPWM_CTRL2_WMASK = 16'hF7FF;

   // ****************************************
   // Field codes
   // ****************************************
   typedef enum logic [2:0] {
      OCPWM_OFF      = 3'h0,
      OCPWM_SGL_HIGH = 3'h1,
      OCPWM_SGL_LOW  = 3'h2,
      OCPWM_SGL_TOG  = 3'h3,
      OCPWM_DBL_ONE  = 3'h4,
      OCPWM_DBL_CONT = 3'h5,
      OCPWM_EDGE     = 3'h6,
      OCPWM_CENTER   = 3'h7
   } ocpwm_mode_t;

   localparam logic [2:0] OCPWM_TB_SYS = 3'h7;
   localparam logic [2:0] OCPWM_TB_T1  = 3'h4;
   localparam logic [2:0] OCPWM_TB_T5  = 3'h3;
   localparam logic [2:0] OCPWM_TB_T4  = 3'h2;
   localparam logic [2:0] OCPWM_TB_T3  = 3'h1;

   localparam logic [4:0] OCPWM_SYNC_NONE = 5'h00;
   localparam logic [4:0] OCPWM_SYNC_SELF = 5'h1F;

   localparam logic [15:0] OCPWM_ZERO16 = 16'h0000;
   localparam logic [15:0] OCPWM_ONE16  = 16'h0001;

   // Fine duty: sys_clk cycles added per step of the fine duty field
   localparam logic [2:0] OCPWM_FINE_STEP = 3'h1;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic t5;
      logic t4;
      logic t3;
      logic t1;
   } ocpwm_tick_t;

   typedef struct packed {
      logic       idle_halt;
      logic [2:0] time_base_select;
      logic [2:0] fault_enable;
      logic [2:0] fault_status;
      logic       trigger_status_mode;
      logic [2:0] compare_mode_field;
   } ocpwm_ctrl1_t;

   typedef struct packed {
      logic       fault_mode_select;
      logic       fault_level;
      logic       fault_pin_direction_enable;
      logic       output_invert;
      logic       unused11;
      logic [1:0] fine_duty;
      logic       cascade_enable;
      logic       trigger_sync_select;
      logic       trigger_status;
      logic       output_tristate;
      logic [4:0] sync_source;
   } ocpwm_ctrl2_t;

endpackage

// ### core/ocpwm_core.sv
// Output compare and PWM channel with APB register access
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ocpwm_core
   import ocpwm_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   input  wire ocpwm_tick_t timer_tick,
   input  wire logic [31:0] sync_event,
   input  wire logic        cpu_idle,
   input  wire logic        fault_pin_a,
   input  wire logic        fault_pin_b,
   input  wire logic        comparator_fault,
   input  wire logic        cascade_carry_in,
   input  wire logic        cascade_match_in,
   output logic             cascade_carry_out,
   output logic             cascade_match_out,
   output logic             compare_output_pin,
   output logic             compare_output_oe
);

   // ****************************************
   // Registers and APB slave
   // ****************************************
   ocpwm_ctrl1_t ctrl1;
   ocpwm_ctrl2_t ctrl2;
   logic [15:0]  compare_primary;
   logic [15:0]  compare_secondary;
   logic [15:0]  timer_period;
   logic [15:0]  internal_counter;
   logic [15:0]  buf_pri;
   logic [15:0]  buf_sec;
   logic [1:0]   buf_fine;
   logic         cmp_out;
   logic         shot_done;
   logic         pwm_q;
   logic         fault_active;
   logic [2:0]   fine_hold;
   logic         raw_prev;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OCPWM_ADDR_CTRL1) || (a == OCPWM_ADDR_CTRL2) ||
                (a == OCPWM_ADDR_PRI) || (a == OCPWM_ADDR_SEC) ||
                (a == OCPWM_ADDR_PERIOD) || (a == OCPWM_ADDR_STATUS);
   endfunction

   logic wr_en;
   logic setup;
   logic wr_c1;
   logic wr_c2;
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && addr_ok(paddr);
   assign wr_c1 = wr_en && (paddr == OCPWM_ADDR_CTRL1);
   assign wr_c2 = wr_en && (paddr == OCPWM_ADDR_CTRL2);
   // Read data is captured in the setup cycle, so every access takes one wait-free phase
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         case (paddr)
            OCPWM_ADDR_CTRL1:  prdata <= {16'h0000, 2'b00, ctrl1};
            OCPWM_ADDR_CTRL2:  prdata <= {16'h0000, ctrl2 & OCPWM_CTRL2_WMASK};
            OCPWM_ADDR_PRI:    prdata <= {16'h0000, compare_primary};
            OCPWM_ADDR_SEC:    prdata <= {16'h0000, compare_secondary};
            OCPWM_ADDR_PERIOD: prdata <= {16'h0000, timer_period};
            OCPWM_ADDR_STATUS: prdata <= {13'h0000, fault_active, compare_output_pin,
                                          compare_output_oe, internal_counter};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Mode decode and time base
   // ****************************************
   ocpwm_mode_t mode;
   logic pwm_mode;
   logic tick_sel;
   logic trig_mode;
   logic running;
   logic adv;
   logic src_evt;
   logic sync_clr;
   logic period_match;
   logic pri_match;
   logic sec_match;
   logic cnt_eq_pri;
   logic cnt_eq_sec;

   assign mode     = ocpwm_mode_t'(ctrl1.compare_mode_field);
   assign pwm_mode = (mode == OCPWM_EDGE) || (mode == OCPWM_CENTER);

   always_comb begin
      case (ctrl1.time_base_select)
         OCPWM_TB_SYS: tick_sel = 1'b1;
         OCPWM_TB_T1:  tick_sel = timer_tick.t1;
         OCPWM_TB_T5:  tick_sel = timer_tick.t5;
         OCPWM_TB_T4:  tick_sel = timer_tick.t4;
         OCPWM_TB_T3:  tick_sel = timer_tick.t3;
         default:      tick_sel = 1'b0;
      endcase
   end

   assign trig_mode = ctrl2.trigger_sync_select && (ctrl2.sync_source != OCPWM_SYNC_NONE);
   // Counter is held clear until triggered; disabled channel does not count
   assign running = (mode != OCPWM_OFF) && (!trig_mode || ctrl2.trigger_status);
   // High half of a cascaded pair advances on the low half's wrap
   assign adv = running && !(ctrl1.idle_halt && cpu_idle) &&
                (ctrl2.cascade_enable ? cascade_carry_in : tick_sel);

   assign period_match = adv && (internal_counter == timer_period);
   // Self selection resolves to the period match; sync_event[31] is not used
   assign src_evt = (ctrl2.sync_source == OCPWM_SYNC_SELF) ? period_match
                                                            : sync_event[ctrl2.sync_source];
   assign sync_clr = !ctrl2.trigger_sync_select &&
                     (ctrl2.sync_source != OCPWM_SYNC_NONE) && src_evt;

   assign cnt_eq_pri = (internal_counter == (pwm_mode ? buf_pri : compare_primary));
   assign cnt_eq_sec = (internal_counter == (pwm_mode ? buf_sec : compare_secondary));
   assign cascade_match_out = cnt_eq_pri || cnt_eq_sec;
   assign cascade_carry_out = period_match;
   // In cascade the high half only fires when the low half matches too
   assign pri_match = adv && cnt_eq_pri && (!ctrl2.cascade_enable || cascade_match_in);
   assign sec_match = adv && cnt_eq_sec && (!ctrl2.cascade_enable || cascade_match_in);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         internal_counter <= OCPWM_ZERO16;
      end else if (sync_clr || period_match || mode == OCPWM_OFF ||
                   (trig_mode && !ctrl2.trigger_status)) begin
         // Untriggered counter is held clear, so a trigger always starts from zero
         internal_counter <= OCPWM_ZERO16;
      end else if (adv) begin
         internal_counter <= internal_counter + OCPWM_ONE16;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   logic [2:0] fault_src;
   logic [2:0] next_fstat;
   logic       next_trig;
   assign fault_src = ctrl1.fault_enable & {comparator_fault, fault_pin_b, fault_pin_a};

   always_comb begin
      next_fstat = ctrl1.fault_status;
      if (wr_c1) begin
         next_fstat = next_fstat & pwdata[6:4];
      end
      if (pwm_mode) begin
         next_fstat = next_fstat | fault_src;
      end
   end

   always_comb begin
      next_trig = ctrl2.trigger_status;
      if (wr_c2) begin
         next_trig = pwdata[6];
      end
      if (ctrl1.trigger_status_mode && sec_match) begin
         next_trig = 1'b0;
      end
      if (trig_mode && src_evt) begin
         next_trig = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1 <= ocpwm_ctrl1_t'(OCPWM_CTRL1_RESET[13:0]);
         ctrl2 <= ocpwm_ctrl2_t'(OCPWM_CTRL2_RESET);
      end else begin
         if (wr_c1) begin
            ctrl1 <= ocpwm_ctrl1_t'(pwdata[13:0] & OCPWM_CTRL1_WMASK[13:0]);
         end
         ctrl1.fault_status <= next_fstat;
         if (wr_c2) begin
            ctrl2 <= ocpwm_ctrl2_t'(pwdata[15:0] & OCPWM_CTRL2_WMASK);
         end
         ctrl2.trigger_status <= next_trig;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_primary   <= OCPWM_ZERO16;
         compare_secondary <= OCPWM_ZERO16;
         timer_period      <= OCPWM_ZERO16;
      end else if (wr_en) begin
         if (paddr == OCPWM_ADDR_PRI) begin
            compare_primary <= pwdata[15:0];
         end
         if (paddr == OCPWM_ADDR_SEC) begin
            compare_secondary <= pwdata[15:0];
         end
         if (paddr == OCPWM_ADDR_PERIOD) begin
            timer_period <= pwdata[15:0];
         end
      end
   end

   // Duty buffers follow the live values outside PWM, load at period end inside it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_pri  <= OCPWM_ZERO16;
         buf_sec  <= OCPWM_ZERO16;
         buf_fine <= 2'b00;
      end else if (!pwm_mode || period_match) begin
         buf_pri  <= compare_primary;
         buf_sec  <= compare_secondary;
         buf_fine <= ctrl2.fine_duty;
      end
   end

   // ****************************************
   // Compare modes
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_out   <= 1'b0;
         shot_done <= 1'b0;
      end else if (wr_c1) begin
         // Rewriting control one re-arms a single shot
         cmp_out   <= (pwdata[2:0] == OCPWM_SGL_LOW);
         shot_done <= 1'b0;
      end else begin
         case (mode)
            OCPWM_SGL_HIGH: if (pri_match && !shot_done) begin
               cmp_out   <= 1'b1;
               shot_done <= 1'b1;
            end
            OCPWM_SGL_LOW: if (pri_match && !shot_done) begin
               cmp_out   <= 1'b0;
               shot_done <= 1'b1;
            end
            OCPWM_SGL_TOG: if (pri_match) begin
               cmp_out <= !cmp_out;
            end
            OCPWM_DBL_ONE: begin
               if (pri_match && !cmp_out && !shot_done) begin
                  cmp_out <= 1'b1;
               end else if (sec_match && cmp_out) begin
                  cmp_out   <= 1'b0;
                  shot_done <= 1'b1;
               end
            end
            OCPWM_DBL_CONT: begin
               if (pri_match && !cmp_out) begin
                  cmp_out <= 1'b1;
               end else if (sec_match && cmp_out) begin
                  cmp_out <= 1'b0;
               end
            end
            default: cmp_out <= 1'b0;
         endcase
      end
   end

   // ****************************************
   // PWM and fine falling-edge delay
   // ****************************************
   logic pwm_raw;
   always_comb begin
      if (buf_sec > timer_period) begin
         pwm_raw = 1'b1;
      end else if (mode == OCPWM_CENTER) begin
         pwm_raw = (internal_counter >= buf_pri) && (internal_counter < buf_sec);
      end else begin
         pwm_raw = (internal_counter < buf_sec);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_prev  <= 1'b0;
         fine_hold <= 3'h0;
      end else begin
         raw_prev <= pwm_raw && pwm_mode;
         if (raw_prev && !(pwm_raw && pwm_mode) && buf_fine != 2'b00) begin
            fine_hold <= OCPWM_FINE_STEP * {1'b0, buf_fine};
         end else if (fine_hold != 3'h0) begin
            fine_hold <= fine_hold - 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_q <= 1'b0;
      end else begin
         pwm_q <= pwm_mode && (pwm_raw || (raw_prev && buf_fine != 2'b00) ||
                              fine_hold > 3'h1);
      end
   end

   // ****************************************
   // Fault handling and pin drive
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_active <= 1'b0;
      end else if (!pwm_mode) begin
         fault_active <= 1'b0;
      end else if (fault_src != 3'b000) begin
         fault_active <= 1'b1;
      end else if (ctrl2.fault_mode_select) begin
         if (ctrl1.fault_status == 3'b000) begin
            fault_active <= 1'b0;
         end
      end else if (period_match) begin
         fault_active <= 1'b0;
      end
   end

   logic next_pin;
   logic next_oe;
   always_comb begin
      if (mode == OCPWM_OFF) begin
         next_pin = 1'b0;
      end else if (pwm_mode) begin
         next_pin = fault_active ? ctrl2.fault_level : pwm_q;
      end else begin
         next_pin = cmp_out;
      end
      next_pin = next_pin ^ ctrl2.output_invert;
      next_oe  = !ctrl2.output_tristate ||
                 (fault_active && ctrl2.fault_pin_direction_enable);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_output_pin <= 1'b0;
         compare_output_oe  <= 1'b0;
      end else begin
         compare_output_pin <= next_pin;
         compare_output_oe  <= next_oe;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking ac @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_period_wrap: assert property (period_match |=> internal_counter == OCPWM_ZERO16)
      else $error("counter did not wrap at period");
   a_duty_latch: assert property (pwm_mode && !period_match |=> $stable(buf_sec))
      else $error("duty buffer changed outside period end");
   a_zero_duty: assert property (mode == OCPWM_EDGE && buf_sec == OCPWM_ZERO16 && !fault_active
      && fine_hold == 3'h0 && !raw_prev |=> ##1 !pwm_q || $past(buf_sec) != OCPWM_ZERO16)
      else $error("zero duty drove pin high");
   a_full_duty: assert property (pwm_mode && buf_sec > timer_period |=> pwm_q)
      else $error("full duty not high");
   a_fault_gate: assert property (!pwm_mode && !wr_c1 |=> $stable(ctrl1.fault_status))
      else $error("fault status moved outside PWM");
   a_fault_set: assert property (pwm_mode && fault_src[0] |=> ctrl1.fault_status[0])
      else $error("fault pin A status not set");
   a_trig_clear: assert property (ctrl1.trigger_status_mode && sec_match && !(trig_mode
      && src_evt) |=> !ctrl2.trigger_status)
      else $error("trigger status not cleared");
   a_fault_level: assert property (pwm_mode && fault_active && mode == $past(mode)
      |=> compare_output_pin == ($past(ctrl2.fault_level) ^ $past(ctrl2.output_invert)))
      else $error("fault level not driven");
   a_off_low: assert property (mode == OCPWM_OFF && !ctrl2.output_invert |=>
      !compare_output_pin)
      else $error("disabled channel drove pin");
   a_single_high: assert property (mode == OCPWM_SGL_HIGH && pri_match && !shot_done && !wr_c1
      |=> cmp_out ##1 cmp_out)
      else $error("single shot did not go high");

   c_pwm_period: cover property (pwm_mode && period_match ##1 pwm_mode);
   c_fault_hit: cover property (pwm_mode && fault_src != 3'b000 ##1 fault_active);
   c_dbl_pulse: cover property (mode == OCPWM_DBL_ONE && cmp_out ##[1:20] shot_done);

endmodule

// ### tb/ocpwm_far_end.sv
// Far-side model: fault sources and the load on the compare output pin
`timescale 1ns/1ps
module ocpwm_far_end (
   input  wire logic       sys_clk,
   input  wire logic [2:0] fault_cmd,
   input  wire logic       pin,
   input  wire logic       oe,
   output logic            fault_pin_a,
   output logic            fault_pin_b,
   output logic            comparator_fault,
   output logic            pin_seen
);
   // ****************************************
   // Fault sources and pin load
   // ****************************************
   logic last_pin = 1'b0;
   // Fault levels move just after an edge, as a source behind a sync stage would
   always_ff @(posedge sys_clk) begin
      fault_pin_a      <= fault_cmd[0];
      fault_pin_b      <= fault_cmd[1];
      comparator_fault <= fault_cmd[2];
      if (oe) begin
         last_pin <= pin;
      end
   end
   // No pull on the pin: a released line shows the inverse so a stale level never passes
   assign pin_seen = oe ? pin : ~last_pin;
endmodule

// ### tb/tb_output_compare_pwm_unit.sv
// Self-checking testbench of the output compare / PWM channel
`timescale 1ns/1ps
module tb_output_compare_pwm_unit
   import ocpwm_pkg::*;
;
   // ****************************************
   // Signals and design
   // ****************************************
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0;
   logic [2:0]  fault_cmd = 3'h0;
   logic        tick_t1   = 1'b0;
   logic [31:0] s         = 32'h55C9;
   logic        pready, pslverr, pin, oe, fa, fb, fc, pin_seen, err;
   logic [31:0] prdata, q, c;
   int          errors    = 0;
   int          cmp_count = 0;
   int          cyc       = 0;
   int          ex[8]     = '{0, 40, 0, 20, 3, 12, 20, 12};

   ocpwm_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .timer_tick(ocpwm_tick_t'({3'b000, tick_t1})),
      .sync_event(32'h0), .cpu_idle(1'b0), .fault_pin_a(fa), .fault_pin_b(fb),
      .comparator_fault(fc), .cascade_carry_in(1'b0), .cascade_match_in(1'b0),
      .cascade_carry_out(), .cascade_match_out(), .compare_output_pin(pin),
      .compare_output_oe(oe));

   ocpwm_far_end far (.sys_clk(sys_clk), .fault_cmd(fault_cmd), .pin(pin), .oe(oe),
      .fault_pin_a(fa), .fault_pin_b(fb), .comparator_fault(fc), .pin_seen(pin_seen));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Timer one counts on every other clock
   always @(posedge sys_clk) begin
      tick_t1 <= ~tick_t1;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // High counts per period: edge from zero to secondary, center from primary to secondary
   function automatic int pwm_high(input int ctr, input int pri, input int sec, input int per);
      if (sec > per) return per + 1;
      if (ctr == 0) return sec;
      return (sec > pri) ? sec - pri : 0;
   endfunction

   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is seen high; no latency assumed
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= wr_en;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) errors++;
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // Channel off first so every setup starts from a cleared counter
   task automatic cfg(input logic [15:0] c1, input logic [15:0] c2, input int pri,
                      input int sec, input int per);
      wr(OCPWM_ADDR_CTRL1, 32'h0);
      wr(OCPWM_ADDR_PRI, 32'(pri));
      wr(OCPWM_ADDR_SEC, 32'(sec));
      wr(OCPWM_ADDR_PERIOD, 32'(per));
      wr(OCPWM_ADDR_CTRL2, {16'h0, c2});
      wr(OCPWM_ADDR_CTRL1, {16'h0, c1});
   endtask

   // Four whole periods, so the count does not depend on phase
   task automatic count(input int wait_n, input int per);
      repeat (wait_n) @(posedge sys_clk);
      c = 32'h0;
      repeat (4 * (per + 1)) begin
         @(posedge sys_clk);
         c = c + 32'(pin_seen);
      end
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      int i, m, per, sec, pri, e;
      logic [15:0] c1;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(OCPWM_ADDR_CTRL1);
      chk(q, 32'h0);
      rd(OCPWM_ADDR_CTRL2);
      chk(q, 32'h0000_000C);
      rd(8'h18);
      chk({q[31:1], err}, 32'h1);
      for (i = 0; i < 4; i++) begin
         s = lfsr(s);
         wr(OCPWM_ADDR_CTRL1, 32'h0);
         wr(OCPWM_ADDR_CTRL2, {16'h0, s[15:0]});
         rd(OCPWM_ADDR_CTRL2);
         chk(q, {16'h0, s[15:0] & OCPWM_CTRL2_WMASK});
         wr(OCPWM_ADDR_CTRL2, 32'h0);
         wr(OCPWM_ADDR_CTRL1, {16'h0, s[31:16]});
         rd(OCPWM_ADDR_CTRL1);
         chk(q, {16'h0, s[31:16] & 16'h3F8F});
      end
      for (i = 0; i < 8; i++) begin
         cfg({3'b000, OCPWM_TB_SYS, 7'h00, i[2:0]}, 16'h0000, 2, 5, 9);
         count((i == 4) ? 0 : 24, 9);
         chk(c, ex[i]);
      end
      cfg(16'h1C06, 16'h0000, 0, 0, 0);
      count(8, 0);
      chk(c, 32'h0);
      cfg(16'h1C06, 16'h0000, 2, 12, 9);
      count(24, 9);
      chk(c, 32'd40);
      // Fine duty 11 stretches each high phase by three sys_clk cycles
      cfg(16'h1C06, 16'h0600, 0, 4, 11);
      count(30, 11);
      chk(c, 32'(4 * (4 + 3 * int'(OCPWM_FINE_STEP))));
      // Timer one ticks every other clock, so one period takes twenty clocks
      cfg(16'h1006, 16'h0000, 0, 5, 9);
      count(48, 19);
      chk(c, 32'd40);
      for (i = 0; i < 6; i++) begin
         s = lfsr(s);
         per = 3 + int'(s[3:0]);
         sec = int'(s[7:4]);
         pri = int'(s[9:8]);
         m = int'(s[10]);
         e = 4 * pwm_high(m, pri, sec, per);
         if (s[11]) e = 4 * (per + 1) - e;
         cfg({3'b000, OCPWM_TB_SYS, 9'h003, s[10]}, {3'b000, s[11], 12'h000}, pri, sec, per);
         count(2 * per + 6, per);
         chk(c, 32'(e));
      end
      for (i = 0; i < 3; i++) begin
         c1 = 16'h1C06 | (16'h0080 << i);
         cfg(c1, (i == 2) ? 16'h6020 : 16'hE020, 0, 0, 9);
         repeat (8) @(posedge sys_clk);
         chk({31'h0, oe}, 32'h0);
         fault_cmd[i] <= 1'b1;
         repeat (6) @(posedge sys_clk);
         chk({31'h0, pin}, 32'h1);
         chk({31'h0, oe}, 32'h1);
         rd(OCPWM_ADDR_CTRL1);
         chk(q & 32'h70, 32'h10 << i);
         fault_cmd <= 3'h0;
         repeat (24) @(posedge sys_clk);
         chk({31'h0, pin}, (i == 2) ? 32'h0 : 32'h1);
         wr(OCPWM_ADDR_CTRL1, {16'h0, c1});
         repeat (24) @(posedge sys_clk);
         chk({31'h0, pin}, 32'h0);
         wr(OCPWM_ADDR_CTRL1, {16'h0, (c1 & 16'hFFF8) | 16'h0003});
         fault_cmd[i] <= 1'b1;
         repeat (6) @(posedge sys_clk);
         rd(OCPWM_ADDR_CTRL1);
         chk(q & 32'h70, 32'h0);
         fault_cmd <= 3'h0;
      end
      for (m = 0; m < 2; m++) begin
         // Trigger source is another unit, never this channel
         cfg(16'h1C06 | 16'(m << 3), 16'h00C1, 2, 5, 9);
         repeat (30) @(posedge sys_clk);
         rd(OCPWM_ADDR_CTRL2);
         chk(q & 32'h40, (m == 1) ? 32'h0 : 32'h40);
      end
      stop_test();
   end
endmodule
